// [hw/pds_supervisor.v]
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "pds_regs.vh"

module pds_supervisor #(
  parameter [26:0] START_CYCLES = `PDS_START_CYCLES,
  parameter [30:0] RES_CYCLES   = `PDS_RES_CYCLES,
  parameter [16:0] RATED_RPM    = `PDS_RATED_RPM
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rd_data,
  output reg         irq,
  // control connector contacts, high when closed to common
  input  wire        start_input,
  input  wire        maintained_run_input,
  // motor drive side
  input  wire        motor_tach,
  input  wire [16:0] speed_rpm,
  input  wire [11:0] dc_current,
  input  wire        drive_fault,
  output reg         drive_enable,
  output reg         freq_meas_out,
  // relays and front lamps
  output reg         status_relay,
  output reg         fault_relay,
  output reg         led_power,
  output reg         led_run_up,
  output reg         led_at_speed,
  output reg         led_fault
);

  // --------------------------------------------------------------------
  // states and derived figures
  // --------------------------------------------------------------------
  localparam [1:0] ST_STANDSTILL = 2'h0;
  localparam [1:0] ST_RUN_UP     = 2'h1;
  localparam [1:0] ST_AT_SPEED   = 2'h2;
  localparam [1:0] ST_FAULT      = 2'h3;
  // at-speed threshold, ninety percent of rated, truncated to whole rpm
  localparam integer SPEED_90_FULL = (RATED_RPM * 9) / 10;
  localparam [16:0]  SPEED_90      = SPEED_90_FULL[16:0];

  // true while speed sits in the resonance band
  // both edges of the band count as inside it
  function in_band;
    input [16:0] rpm;
    begin
      in_band = (rpm >= `PDS_BAND_LO) && (rpm <= `PDS_BAND_HI);
    end
  endfunction

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  wire [2:0] pin_raw = {motor_tach, maintained_run_input, start_input};
  reg  [2:0] pin_s1;
  reg  [2:0] pin_s2;
  reg  [2:0] pin_s3;
  reg  [2:0] pin_f;

  // a change counts only once stages two and three agree
  // stage one may go metastable, so nothing but stage two reads it
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_f[gi]  <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_f[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  wire start_f = pin_f[0];
  wire run_f   = pin_f[1];
  wire tach_f  = pin_f[2];

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg  [7:0]  cfg;
  reg  [11:0] limit;
  reg  [3:0]  irq_status;
  reg  [3:0]  irq_enable;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [26:0] hold_cnt;
  reg  [30:0] res_cnt;
  reg  [2:0]  pwr_cnt;
  reg         auto_start;

  wire        res_en  = cfg[`PDS_CFG_RES_EN];
  wire        srel_func = cfg[`PDS_CFG_SREL_FUNC];
  wire [1:0]  frel_func = cfg[`PDS_CFG_FREL_HI:`PDS_CFG_FREL_LO];
  wire [1:0]  mode    = cfg[`PDS_CFG_MODE_HI:`PDS_CFG_MODE_LO];
  wire        band    = in_band(speed_rpm);

  // software writes; resonance monitoring on at reset
  // monitoring default on
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg        <= `PDS_CFG_RESET;
      limit      <= `PDS_LIMIT_RESET;
      irq_enable <= 4'h0;
    end else if (wr_en) begin
      case (addr)
        `PDS_ADDR_CONFIG:     cfg        <= wr_data[7:0];
        `PDS_ADDR_LIMIT:      limit      <= wr_data[11:0];
        `PDS_ADDR_IRQ_ENABLE: irq_enable <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // start and stop commands
  // --------------------------------------------------------------------
  // an open loop outranks any start, a held button included
  // stop loop opened
  wire stop_cmd = ~run_f;

  // pushbutton hold timer, restarts whenever the button lets go
  // saturating, so a button held for minutes never wraps to a false count
  // three second hold
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt <= 27'h0;
    end else if (!(start_f && run_f)) begin
      hold_cnt <= 27'h0;
    end else if (hold_cnt != START_CYCLES) begin
      hold_cnt <= hold_cnt + 27'h1;
    end
  end

  // power-up check waits for the synchronisers to settle first; it looks
  // exactly once, as the counter takes its last step, so a later short
  // press can never pass for a tied jumper and dodge the hold time
  // tied inputs start at once
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_cnt    <= 3'h0;
      auto_start <= 1'b0;
    end else begin
      auto_start <= start_f && run_f && (pwr_cnt == `PDS_PWRUP_CYCLES - 3'h1);
      if (pwr_cnt != `PDS_PWRUP_CYCLES) begin
        pwr_cnt <= pwr_cnt + 3'h1;
      end
    end
  end

  // switch mode starts when start and loop are both closed and only an open loop stops it; frequency mode treats start as permanently tied
  // run while closed
  reg start_cmd;
  always @* begin
    case (mode)
      `PDS_MODE_SWITCH: start_cmd = start_f && run_f;
      `PDS_MODE_FREQ:   start_cmd = run_f;
      default:          start_cmd = (hold_cnt == START_CYCLES) || auto_start;
    endcase
  end

  // --------------------------------------------------------------------
  // resonance watchdog
  // --------------------------------------------------------------------
  // counts only while turning with monitoring on; leaving the band resets it
  // a speed dithering at a band edge restarts the dwell, so it trips late
  // band dwell timer
  wire running  = (state == ST_RUN_UP) || (state == ST_AT_SPEED);
  wire res_trip = res_en && running && band && (res_cnt == RES_CYCLES);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_cnt <= 31'h0;
    end else if (!(res_en && running && band)) begin
      res_cnt <= 31'h0;
    end else if (res_cnt != RES_CYCLES) begin
      res_cnt <= res_cnt + 31'h1;
    end
  end

  // --------------------------------------------------------------------
  // supervisor state machine
  // --------------------------------------------------------------------
  // fault is left only through a stop, so a restart needs a fresh start
  // stop clears fault
  always @* begin
    case (state)
      ST_STANDSTILL: begin
        next_state = start_cmd && !stop_cmd ? ST_RUN_UP : ST_STANDSTILL;
      end
      ST_RUN_UP: begin
        if (stop_cmd) begin
          next_state = ST_STANDSTILL;
        end else if (drive_fault || res_trip) begin
          next_state = ST_FAULT;
        end else if (speed_rpm >= SPEED_90) begin
          next_state = ST_AT_SPEED;
        end else begin
          next_state = ST_RUN_UP;
        end
      end
      ST_AT_SPEED: begin
        if (stop_cmd) begin
          next_state = ST_STANDSTILL;
        end else if (drive_fault || res_trip) begin
          next_state = ST_FAULT;
        end else if (speed_rpm < SPEED_90) begin
          next_state = ST_RUN_UP;
        end else begin
          next_state = ST_AT_SPEED;
        end
      end
      ST_FAULT: begin
        // a held start cannot leave fault; the loop must open first
        next_state = stop_cmd ? ST_STANDSTILL : ST_FAULT;
      end
      default: begin
        next_state = ST_STANDSTILL;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_STANDSTILL;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // relay and lamp decode
  // --------------------------------------------------------------------
  reg next_srel;
  reg next_frel;
  reg next_status_relay;
  reg next_fault_relay;

  // decoded from next_state so the registered relays line up with state
  // default at-speed and fault
  always @* begin
    if (srel_func == `PDS_SREL_PRESSURE) begin
      next_srel = (next_state == ST_AT_SPEED) && (dc_current < limit);
    end else begin
      next_srel = (next_state == ST_AT_SPEED);
    end
    case (frel_func)
      `PDS_FREL_FAULT:   next_frel = (next_state == ST_FAULT);
      `PDS_FREL_BACKING: next_frel = (next_state != ST_STANDSTILL);
      default:           next_frel = 1'b0;
    endcase
    next_status_relay = next_srel ^ cfg[`PDS_CFG_SREL_NC];
    next_fault_relay  = next_frel ^ cfg[`PDS_CFG_FREL_NC];
  end

  // outputs registered so the relays never see decode glitches
  // run-up then at-speed lamp
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_relay  <= 1'b0;
      fault_relay   <= 1'b0;
      drive_enable  <= 1'b0;
      led_power     <= 1'b0;
      led_run_up    <= 1'b0;
      led_at_speed  <= 1'b0;
      led_fault     <= 1'b0;
      freq_meas_out <= 1'b0;
    end else begin
      status_relay  <= next_status_relay;
      fault_relay   <= next_fault_relay;
      // enable and lamps share next_state, so they switch on one edge
      drive_enable  <= (next_state == ST_RUN_UP) || (next_state == ST_AT_SPEED);
      led_power     <= 1'b1;
      led_run_up    <= (next_state == ST_RUN_UP);
      led_at_speed  <= (next_state == ST_AT_SPEED);
      led_fault     <= (next_state == ST_FAULT);
      // tach passes only in frequency mode; otherwise the pin idles low
      // frequency presented
      freq_meas_out <= (mode == `PDS_MODE_FREQ) && tach_f;
    end
  end

  // --------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------
  // fault, at-speed and stopped events are entries into a state, so each one is counted once
  wire [3:0] events;
  assign events[`PDS_EV_FAULT]     = (next_state == ST_FAULT) && (state != ST_FAULT);
  assign events[`PDS_EV_AT_SPEED]  = (next_state == ST_AT_SPEED) && (state != ST_AT_SPEED);
  assign events[`PDS_EV_STOPPED]   = (next_state == ST_STANDSTILL) && (state != ST_STANDSTILL);
  assign events[`PDS_EV_RESONANCE] = res_trip;

  wire [3:0] irq_clr = (wr_en && addr == `PDS_ADDR_IRQ_CLEAR) ? wr_data[3:0] : 4'h0;
  // a new event beats a clear in the same cycle
  wire [3:0] next_irq_status = (irq_status & ~irq_clr) | events;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_status <= 4'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq        <= |(next_irq_status & irq_enable);
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  // data stands one cycle after the strobe and is zero otherwise
  // an unmapped address answers zero rather than stale data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0;
    end else if (rd_en) begin
      case (addr)
        `PDS_ADDR_CONFIG:     rd_data <= {24'h0, cfg};
        `PDS_ADDR_LIMIT:      rd_data <= {20'h0, limit};
        `PDS_ADDR_STATE:      rd_data <= {27'h0, band, run_f, start_f, state};
        `PDS_ADDR_IRQ_STATUS: rd_data <= {28'h0, irq_status};
        `PDS_ADDR_IRQ_ENABLE: rd_data <= {28'h0, irq_enable};
        default:              rd_data <= 32'h0;
      endcase
    end else begin
      rd_data <= 32'h0;
    end
  end

endmodule

// [hw/pds_regs.vh]
`ifndef PDS_REGS_VH
`define PDS_REGS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define PDS_ADDR_CONFIG     8'h00
`define PDS_ADDR_LIMIT      8'h04
`define PDS_ADDR_STATE      8'h08
`define PDS_ADDR_IRQ_STATUS 8'h0c
`define PDS_ADDR_IRQ_CLEAR  8'h10
`define PDS_ADDR_IRQ_ENABLE 8'h14

// ----------------------------------------------------------------------
// config fields and reset value
// ----------------------------------------------------------------------
`define PDS_CFG_RES_EN      0
`define PDS_CFG_SREL_FUNC   1
`define PDS_CFG_FREL_LO     2
`define PDS_CFG_FREL_HI     3
`define PDS_CFG_SREL_NC     4
`define PDS_CFG_FREL_NC     5
`define PDS_CFG_MODE_LO     6
`define PDS_CFG_MODE_HI     7
`define PDS_CFG_RESET       8'h01
`define PDS_LIMIT_RESET     12'h000

// relay function and input mode codes
`define PDS_SREL_AT_SPEED   1'b0
`define PDS_SREL_PRESSURE   1'b1
`define PDS_FREL_FAULT      2'h0
`define PDS_FREL_BACKING    2'h1
`define PDS_MODE_BUTTON     2'h0
`define PDS_MODE_SWITCH     2'h1
`define PDS_MODE_FREQ       2'h2

// interrupt event bits
`define PDS_EV_FAULT        0
`define PDS_EV_AT_SPEED     1
`define PDS_EV_STOPPED      2
`define PDS_EV_RESONANCE    3

// ----------------------------------------------------------------------
// timing and speed figures
// ----------------------------------------------------------------------
`define PDS_CLK_HZ          25000000
`define PDS_START_HOLD_S    3
`define PDS_RES_TIME_S      60
// hold and dwell counts at the clock rate, sized to their counters
`define PDS_START_CYCLES    27'h47868c0
`define PDS_RES_CYCLES      31'h59682f00
`define PDS_BAND_LO         17'h0afc8
`define PDS_BAND_HI         17'h0d6d8
`define PDS_RATED_RPM       17'h0ea60
`define PDS_PWRUP_CYCLES    3'h7

`endif

// [verif/pds_monitor.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// supervisor checker
// ----------------------------------------------------------------
module pds_monitor #(
  parameter [26:0] START_CYCLES = 27'h14,
  parameter [30:0] RES_CYCLES   = 31'h32
) (
  // clock, reset, register port
  input wire        clk_sys,
  input wire        rst,
  input wire [7:0]  addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data,
  input wire        irq,
  // contacts and drive
  input wire        start_input,
  input wire        maintained_run_input,
  input wire [16:0] speed_rpm,
  input wire        drive_fault,
  input wire        drive_enable,
  // relays and lamps
  input wire        status_relay,
  input wire        fault_relay,
  input wire        led_power,
  input wire        led_run_up,
  input wire        led_at_speed,
  input wire        led_fault
);
  reg [7:0] cfg;
  reg [7:0] cfg_q;
  reg       sp;
  reg [7:0] hold;
  reg [7:0] band;
  reg [7:0] up;
  wire      in_band = speed_rpm >= 17'h0afc8 && speed_rpm <= 17'h0d6d8;
  wire      cs = cfg == cfg_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow config; press length saturates so tied contacts never wrap
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg <= 8'h01;
      cfg_q <= 8'h01;
      sp <= 1'b0;
      hold <= 8'h00;
      band <= 8'h00;
      up <= 8'h00;
    end else begin
      if (wr_en && addr == 8'h00) cfg <= wr_data[7:0];
      cfg_q <= cfg;
      sp <= start_input;
      if (start_input && !sp) hold <= 8'h01;
      else if (start_input && hold != 8'hff) hold <= hold + 8'h01;
      band <= (cfg[0] && drive_enable && in_band) ? band + 8'h01 : 8'h00;
      if (up != 8'hff) up <= up + 8'h01;
    end
  end
  a_start_hold:
    assert property ($rose(drive_enable) && cfg[7:6] != 2'h1 && cfg[7:6] != 2'h2
      && up == 8'hff |-> hold >= START_CYCLES) else $error("start taken too early");
  a_stop_loop:
    assert property (!maintained_run_input [*7] |=> !drive_enable)
    else $error("drive kept on with loop open");
  a_lamp_runup:
    assert property (led_run_up |-> drive_enable && !led_at_speed) else $error("run-up lamp");
  a_power_lamp:
    assert property (!$past(rst) |-> led_power) else $error("power lamp off");
  a_idle_lamps:
    assert property (!drive_enable && !led_fault |-> !led_run_up && !led_at_speed)
    else $error("lamp lit at standstill");
  a_fault_latch:
    assert property (led_fault |-> !drive_enable && !led_run_up && !led_at_speed)
    else $error("drive on in fault");
  a_fault_entry:
    assert property (drive_enable && drive_fault |-> ##[1:3] led_fault)
    else $error("fault not entered");
  a_frel_fault:
    assert property (cs && cfg[3:2] == 2'h0 |-> fault_relay == (led_fault ^ cfg[5]))
    else $error("fault relay wrong");
  a_srel_speed:
    assert property (cs && !cfg[1] |-> status_relay == (led_at_speed ^ cfg[4]))
    else $error("status relay wrong");
  a_frel_backing:
    assert property (cs && cfg[3:2] == 2'h1
      |-> fault_relay == ((drive_enable | led_fault) ^ cfg[5])) else $error("backing relay");
  a_srel_press:
    assert property (cs && cfg[1] && !cfg[4] && status_relay |-> led_at_speed)
    else $error("trigger relay off speed");
  a_res_trip:
    assert property (band <= RES_CYCLES + 31'h8) else $error("resonance not tripped");
  a_rd_idle:
    assert property (!$past(rd_en) |-> rd_data == 32'h0) else $error("read data not idle");
  c_speed: cover property ($rose(led_at_speed));
  c_fault: cover property ($rose(led_fault));
  c_irq: cover property ($rose(irq));
endmodule

bind pds_supervisor pds_monitor #(.START_CYCLES(START_CYCLES), .RES_CYCLES(RES_CYCLES)) mon_u (
  .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .start_input(start_input),
  .maintained_run_input(maintained_run_input), .speed_rpm(speed_rpm),
  .drive_fault(drive_fault), .drive_enable(drive_enable), .status_relay(status_relay),
  .fault_relay(fault_relay), .led_power(led_power), .led_run_up(led_run_up),
  .led_at_speed(led_at_speed), .led_fault(led_fault));

// [verif/pds_contacts.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// contact model: start button, stop loop, tie jumper
// ----------------------------------------------------------------
module pds_contacts (
  // clock
  input  wire       clk_sys,
  // commands from the bench
  input  wire       tied,
  input  wire       run_closed,
  input  wire       press,
  input  wire [7:0] press_len,
  // contacts toward the block
  output reg        start_input,
  output wire       maintained_run_input
);
  reg [7:0] left;
  initial left = 8'h00;
  assign maintained_run_input = run_closed;
  always @(posedge clk_sys) begin
    if (press) left <= press_len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // jumper ties start to common for good
  always @* start_input = tied || left != 8'h00;
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
`include "pds_regs.vh"
`define CHK(a, b, m) begin n_checks++; \
  if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
  reg        clk_sys, rst, wr_en, rd_en, motor_tach, drive_fault;
  reg        tied, run_closed, press;
  reg [7:0]  addr, press_len;
  reg [31:0] wr_data, rdv;
  reg [16:0] speed_rpm;
  reg [11:0] dc_current;
  wire [31:0] rd_data;
  wire       irq, start_input, maintained_run_input, drive_enable, freq_meas_out;
  wire       status_relay, fault_relay, led_power, led_run_up, led_at_speed, led_fault;
  int        error_cnt, n_checks, cyc;
  wire [3:0] lamps = {led_power, led_run_up, led_at_speed, led_fault};
  pds_supervisor #(.START_CYCLES(27'h14), .RES_CYCLES(31'h32)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .start_input(start_input),
    .maintained_run_input(maintained_run_input), .motor_tach(motor_tach),
    .speed_rpm(speed_rpm), .dc_current(dc_current), .drive_fault(drive_fault),
    .drive_enable(drive_enable), .freq_meas_out(freq_meas_out),
    .status_relay(status_relay), .fault_relay(fault_relay), .led_power(led_power),
    .led_run_up(led_run_up), .led_at_speed(led_at_speed), .led_fault(led_fault));
  pds_contacts ct_u (.clk_sys(clk_sys), .tied(tied), .run_closed(run_closed),
    .press(press), .press_len(press_len), .start_input(start_input),
    .maintained_run_input(maintained_run_input));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize;
    end
  end
  task summarize;
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // extra edge at the end keeps strobes from being set twice at one edge
  task wr(input [7:0] a, input [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    tick(1);
    wr_en <= 1'b0;
    tick(1);
  endtask
  task rd(input [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    tick(1);
    rd_en <= 1'b0;
    #1 rdv = rd_data;
    tick(1);
  endtask
  task push(input [7:0] n);
    press <= 1'b1;
    press_len <= n;
    tick(1);
    press <= 1'b0;
    tick(n + 10);
  endtask
  task restart;
    run_closed <= 1'b0;
    tick(10);
    run_closed <= 1'b1;
    tick(8);
    push(8'h1e);
  endtask
  initial begin
    {rst, tied, run_closed} = 3'h7;
    {wr_en, rd_en, motor_tach, drive_fault, press} = 5'h00;
    {addr, press_len, wr_data, rdv, speed_rpm, dc_current} = 0;
    {error_cnt, n_checks, cyc} = 0;
    tick(10);
    rst <= 1'b0;
    tick(20);
    `CHK(drive_enable, 1'b1, "no auto start")
    `CHK(lamps, 4'hc, "run-up lamps")
    rd(`PDS_ADDR_CONFIG);
    `CHK(rdv, 32'h01, "config reset value")
    rd(8'h40);
    `CHK(rdv, 32'h0, "unmapped read")
    speed_rpm <= 17'h0d2f0;
    tick(4);
    `CHK(lamps, 4'ha, "at-speed lamps")
    `CHK({status_relay, fault_relay}, 2'b10, "default relays")
    {tied, run_closed} <= 2'b00;
    speed_rpm <= 17'h0;
    tick(10);
    `CHK(lamps, 4'h8, "lamps after stop")
    `CHK({drive_enable, status_relay}, 2'b00, "loop open")
    run_closed <= 1'b1;
    push(8'h0a);
    `CHK(drive_enable, 1'b0, "short press taken")
    push(8'h1e);
    `CHK(drive_enable, 1'b1, "press refused")
    wr(`PDS_ADDR_IRQ_ENABLE, 32'h1);
    drive_fault <= 1'b1;
    tick(4);
    drive_fault <= 1'b0;
    tick(2);
    `CHK({lamps, fault_relay, irq}, 6'h27, "fault entry")
    push(8'h1e);
    `CHK(led_fault, 1'b1, "fault left by start")
    rd(`PDS_ADDR_IRQ_STATUS);
    `CHK(rdv[0], 1'b1, "fault event")
    wr(`PDS_ADDR_IRQ_CLEAR, 32'h1);
    tick(2);
    `CHK(irq, 1'b0, "irq not cleared")
    restart;
    `CHK({drive_enable, led_fault}, 2'b10, "no restart")
    wr(`PDS_ADDR_IRQ_ENABLE, 32'h0);
    speed_rpm <= 17'h0c350;
    tick(40);
    `CHK(led_fault, 1'b0, "early trip")
    tick(30);
    `CHK({led_fault, irq}, 2'b10, "no trip or irq unmasked")
    rd(`PDS_ADDR_IRQ_STATUS);
    `CHK(rdv[3:0], 4'hf, "resonance and earlier events")
    wr(`PDS_ADDR_CONFIG, 32'h0);
    restart;
    tick(70);
    `CHK({drive_enable, led_fault}, 2'b10, "trip while disabled")
    wr(`PDS_ADDR_CONFIG, 32'h04);
    tick(2);
    `CHK(fault_relay, 1'b1, "backing off while running")
    run_closed <= 1'b0;
    tick(10);
    `CHK(fault_relay, 1'b0, "backing on at standstill")
    wr(`PDS_ADDR_CONFIG, 32'h30);
    tick(2);
    `CHK({status_relay, fault_relay}, 2'b11, "closed-sense relays")
    wr(`PDS_ADDR_CONFIG, 32'h02);
    wr(`PDS_ADDR_LIMIT, 32'h100);
    dc_current <= 12'h080;
    speed_rpm <= 17'h0d2f0;
    restart;
    `CHK({status_relay, fault_relay}, 2'b10, "trigger low current")
    dc_current <= 12'h200;
    tick(4);
    `CHK(status_relay, 1'b0, "trigger high current")
    wr(`PDS_ADDR_CONFIG, 32'h40);
    {tied, run_closed} <= 2'b10;
    tick(12);
    `CHK(drive_enable, 1'b0, "switch open")
    run_closed <= 1'b1;
    tick(12);
    `CHK(drive_enable, 1'b1, "switch closed")
    run_closed <= 1'b0;
    wr(`PDS_ADDR_CONFIG, 32'h80);
    motor_tach <= 1'b1;
    tick(8);
    `CHK(freq_meas_out, 1'b1, "tach high")
    motor_tach <= 1'b0;
    tick(8);
    `CHK(freq_meas_out, 1'b0, "tach low")
    summarize;
  end
endmodule
